/* File: common/sac_pkg.sv */
// Shared constants and types for the conversion control block
package sac_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_INSEL  = 8'h08;
    localparam logic [7:0] ADDR_RES_LO = 8'h0C;
    localparam logic [7:0] ADDR_RES_HI = 8'h10;

    // converter_control_a fields
    localparam int CA_ON     = 7;
    localparam int CA_GO     = 6;
    localparam int CA_AUTO   = 5;
    localparam int CA_DONE   = 4;
    localparam int CA_PS_LSB = 0;

    // converter_control_b fields
    localparam int CB_GAIN_RANGE_SELECT   = 4;
    localparam int CB_TS_LSB = 0;

    // input_select_register fields
    localparam int IS_REF_LSB = 7;
    localparam int IS_LEFT    = 6;
    localparam int IS_SEL_LSB = 0;

    // Reset values
    localparam logic [2:0] PS_RST    = 3'h0;
    localparam logic [2:0] TS_RST    = 3'h0;
    localparam logic [5:0] SEL_RST   = 6'h00;
    localparam logic [2:0] REF_RST   = 3'h0;
    localparam logic [9:0] RES_RST   = 10'h000;

    // Conversion timing in converter clock cycles
    localparam logic [4:0] NORMAL_CYC = 5'd13;
    localparam logic [4:0] FIRST_CYC  = 5'd25;
    localparam logic [4:0] BIT_LEAD   = 5'd12;

    // Input selection codes
    localparam logic [5:0] SEL_SE_LAST = 6'h0A;
    localparam logic [5:0] SEL_TEMP    = 6'h3F;

    // Trigger source code for own completion (free running)
    localparam logic [2:0] TS_SELF = 3'h0;

    typedef enum logic [1:0] {GAIN_1X, GAIN_8X, GAIN_20X, GAIN_32X} sac_gain_e;

    // Selections presented to the analog path
    typedef struct packed {
        logic       on;
        logic [5:0] chan;
        logic [2:0] refsel;
        sac_gain_e  gain;
        logic       bypass;
        logic       temp;
    } sac_analog_s;

endpackage

/* File: rtl/sac_prescaler.sv */
// Converter clock prescaler producing a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module sac_prescaler (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [2:0] div_sel,
    // Converter clock enable
    output logic            tick
);
    logic [6:0] cnt;
    logic [6:0] limit;

    // Divide by 2 to 128; below 8 the comparator sync lags the trial
    assign limit = 7'((9'd2 << div_sel) - 9'd1);
    assign tick  = run && (cnt == limit);

    // Counter held cleared while off or on restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 7'h00;
        end else if (!run || restart) begin
            cnt <= 7'h00;
        end else if (tick) begin
            cnt <= 7'h00;
        end else begin
            cnt <= cnt + 7'h01;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/sac_sar.sv */
// Successive approximation sequencer
`timescale 1ns/1ps
`default_nettype none
module sac_sar (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Sequencing
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic       start,
    input  wire logic       first,
    input  wire logic       cmp_bit,
    // Status and result
    output logic            busy,
    output logic            done,
    output logic [9:0]      result,
    output logic [9:0]      dac_code,
    output logic            sample_hold
);
    typedef enum logic {SAC_IDLE, SAC_CONV} sac_state_e;
    sac_state_e state;
    logic [4:0] cyc;
    logic [4:0] len;
    logic [9:0] mask;

    assign busy        = (state == SAC_CONV);
    assign sample_hold = busy && (cyc < 5'(len - sac_pkg::BIT_LEAD));

    // Sequencer, one step per converter clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= SAC_IDLE;
            cyc      <= 5'h00;
            len      <= sac_pkg::NORMAL_CYC;
            mask     <= 10'h000;
            dac_code <= 10'h000;
            result   <= sac_pkg::RES_RST;
            done     <= 1'b0;
        end else if (!run) begin
            // Converter off: abandon a running conversion
            state <= SAC_IDLE;
            cyc   <= 5'h00;
            mask  <= 10'h000;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                SAC_IDLE: begin
                    if (start) begin
                        state    <= SAC_CONV;
                        cyc      <= 5'h00;
                        len      <= first ? sac_pkg::FIRST_CYC : sac_pkg::NORMAL_CYC;
                        mask     <= 10'h200;
                        dac_code <= 10'h200;
                    end
                end
                SAC_CONV: begin
                    if (tick) begin
                        cyc <= cyc + 5'h01;
                        if (cyc >= 5'(len - sac_pkg::BIT_LEAD) && mask != 10'h000) begin
                            // Keep or drop trial bit, try next lower
                            dac_code <= (cmp_bit ? dac_code : (dac_code & ~mask))
                                        | (mask >> 1);
                            mask     <= mask >> 1;
                        end
                        if (cyc == 5'(len - 5'h01)) begin
                            state  <= SAC_IDLE;
                            result <= dac_code;
                            done   <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: rtl/sac_top.sv */
// Conversion control top: APB registers, start logic, result lock
// Notes on behaviour
// - 10-bit result, low or high aligned
// - Low byte read blocks result updates
// - High byte read lifts the block
// - Completion flag set even when result lost
// - Go bit starts conversion, clears at end
// - Channel change waits for running conversion
// - Trigger edge resets prescaler, starts conversion
// - Held trigger level never restarts
// - Edges during conversion ignored, not queued
// - Trigger flags act regardless of enables
// - Own completion restarts regardless of flag
// - Go works in auto mode, reads busy
// - Analog selections apply only when enabled
// - Eleven single inputs, differential, temperature code
// - Gain by selection and range, else bypassed
// - Reference from supply, pin or internal
// - Normal 13 cycles, first 25 cycles
// - Prescaler runs only while enabled
// - Completion writes result unless locked or low byte requested, sets flag, clears go
`timescale 1ns/1ps
`default_nettype none
module sac_top (
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Trigger flags from other blocks, codes 1 to 7
    input  wire logic [7:1]      trig_flags,
    // Analog path
    input  wire logic            cmp_in,
    output sac_pkg::sac_analog_s analog,
    output logic [9:0]           dac_code,
    output logic                 sample_hold,
    // Completion flag level
    output logic                 conversion_done_flag
);
    logic       converter_on;
    logic       auto_trigger_on;
    logic [2:0] prescale;
    logic       gain_range_select;
    logic [2:0] trigger_source_select;
    logic [5:0] input_select;
    logic       left_align_result;
    logic [2:0] reference_select;
    logic [9:0] result;
    logic       lock;
    logic       first;
    logic       pend;
    logic       trig_prev;
    logic [5:0] lat_sel;
    logic [2:0] lat_ref;
    logic       cmp_s1, cmp_s2, cmp_s3, cmp_bit;
    logic       tick, busy, sar_done, restart;
    logic [9:0] sar_result;
    logic       setup, access, wr, rd_lo, rd_hi, hit, lo_req;
    logic       go_write, trig_lvl, trig_edge, auto_evt;
    logic [31:0] rd_word;
    logic [5:0] use_sel;
    logic [2:0] use_ref;

    // Result byte view for current alignment
    function automatic logic [7:0] res_byte(input logic [9:0] r, input logic left,
                                            input logic hi);
        if (left) begin
            res_byte = hi ? r[9:2] : {r[1:0], 6'h00};
        end else begin
            res_byte = hi ? {6'h00, r[9:8]} : r[7:0];
        end
    endfunction

    // APB phase decode
    assign pready = 1'b1;
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign hit    = (paddr == sac_pkg::ADDR_CTRL_A) || (paddr == sac_pkg::ADDR_CTRL_B)
                 || (paddr == sac_pkg::ADDR_INSEL) || (paddr == sac_pkg::ADDR_RES_LO)
                 || (paddr == sac_pkg::ADDR_RES_HI);
    assign pslverr = access && !hit;
    assign wr      = access && pwrite;
    assign lo_req  = psel && !pwrite && (paddr == sac_pkg::ADDR_RES_LO);
    assign rd_lo   = access && !pwrite && (paddr == sac_pkg::ADDR_RES_LO);
    assign rd_hi   = access && !pwrite && (paddr == sac_pkg::ADDR_RES_HI);

    // Read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        if (paddr == sac_pkg::ADDR_CTRL_A) begin
            rd_word[sac_pkg::CA_ON]   = converter_on;
            rd_word[sac_pkg::CA_GO]   = pend || busy;
            rd_word[sac_pkg::CA_AUTO] = auto_trigger_on;
            rd_word[sac_pkg::CA_DONE] = conversion_done_flag;
            rd_word[sac_pkg::CA_PS_LSB +: 3] = prescale;
        end else if (paddr == sac_pkg::ADDR_CTRL_B) begin
            rd_word[sac_pkg::CB_GAIN_RANGE_SELECT] = gain_range_select;
            rd_word[sac_pkg::CB_TS_LSB +: 3] = trigger_source_select;
        end else if (paddr == sac_pkg::ADDR_INSEL) begin
            rd_word[sac_pkg::IS_REF_LSB +: 3] = reference_select;
            rd_word[sac_pkg::IS_LEFT] = left_align_result;
            rd_word[sac_pkg::IS_SEL_LSB +: 6] = input_select;
        end else if (paddr == sac_pkg::ADDR_RES_LO) begin
            rd_word[7:0] = res_byte(result, left_align_result, 1'b0);
        end else if (paddr == sac_pkg::ADDR_RES_HI) begin
            rd_word[7:0] = res_byte(result, left_align_result, 1'b1);
        end
    end

    // Read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_word;
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_on          <= 1'b0;
            auto_trigger_on       <= 1'b0;
            prescale              <= sac_pkg::PS_RST;
            gain_range_select     <= 1'b0;
            trigger_source_select <= sac_pkg::TS_RST;
            input_select          <= sac_pkg::SEL_RST;
            left_align_result     <= 1'b0;
            reference_select      <= sac_pkg::REF_RST;
        end else if (wr) begin
            if (paddr == sac_pkg::ADDR_CTRL_A) begin
                converter_on    <= pwdata[sac_pkg::CA_ON];
                auto_trigger_on <= pwdata[sac_pkg::CA_AUTO];
                prescale        <= pwdata[sac_pkg::CA_PS_LSB +: 3];
            end else if (paddr == sac_pkg::ADDR_CTRL_B) begin
                gain_range_select     <= pwdata[sac_pkg::CB_GAIN_RANGE_SELECT];
                trigger_source_select <= pwdata[sac_pkg::CB_TS_LSB +: 3];
            end else if (paddr == sac_pkg::ADDR_INSEL) begin
                reference_select  <= pwdata[sac_pkg::IS_REF_LSB +: 3];
                left_align_result <= pwdata[sac_pkg::IS_LEFT];
                input_select      <= pwdata[sac_pkg::IS_SEL_LSB +: 6];
            end
        end
    end

    // Completion flag, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_done_flag <= 1'b0;
        end else begin
            conversion_done_flag <= (conversion_done_flag && !(wr && paddr == sac_pkg::ADDR_CTRL_A
                                     && pwdata[sac_pkg::CA_DONE])) || sar_done;
        end
    end

    // Result store and read lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= sac_pkg::RES_RST;
            lock   <= 1'b0;
        end else begin
            if (sar_done && !lock && !lo_req) begin
                result <= sar_result;
            end
            if (rd_lo) begin
                lock <= 1'b1;
            end else if (rd_hi) begin
                lock <= 1'b0;
            end
        end
    end

    // Trigger selection; raw flags, not gated by their enables
    assign trig_lvl  = (trigger_source_select == sac_pkg::TS_SELF) ? 1'b0
                     : trig_flags[trigger_source_select];
    assign trig_edge = trig_lvl && !trig_prev;
    assign auto_evt  = converter_on && auto_trigger_on && !busy && !pend
                     && ((trigger_source_select == sac_pkg::TS_SELF) ? sar_done
                                                                     : trig_edge);
    assign restart   = auto_evt;
    assign go_write  = wr && (paddr == sac_pkg::ADDR_CTRL_A) && pwdata[sac_pkg::CA_GO]
                     && pwdata[sac_pkg::CA_ON] && !busy;

    // Trigger history follows level every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_lvl;
        end
    end

    // Pending start waits for next converter clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 1'b0;
        end else if (go_write || auto_evt) begin
            pend <= 1'b1;
        end else if (!converter_on) begin
            pend <= 1'b0;
        end else if (tick) begin
            pend <= 1'b0;
        end
    end

    // First conversion after enable is long
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first <= 1'b1;
        end else if (!converter_on) begin
            first <= 1'b1;
        end else if (pend && tick) begin
            first <= 1'b0;
        end
    end

    // Selections locked at conversion start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_sel <= sac_pkg::SEL_RST;
            lat_ref <= sac_pkg::REF_RST;
        end else if (!busy) begin
            lat_sel <= input_select;
            lat_ref <= reference_select;
        end
    end

    // Comparator synchroniser, change taken when stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_s1  <= 1'b0;
            cmp_s2  <= 1'b0;
            cmp_s3  <= 1'b0;
            cmp_bit <= 1'b0;
        end else begin
            cmp_s1 <= cmp_in;
            cmp_s2 <= cmp_s1;
            cmp_s3 <= cmp_s2;
            if (cmp_s2 == cmp_s3) begin
                cmp_bit <= cmp_s3;
            end
        end
    end

    // Analog selections, gated by enable
    assign use_sel = busy ? lat_sel : input_select;
    assign use_ref = busy ? lat_ref : reference_select;
    always_comb begin
        analog        = '0;
        analog.on     = converter_on;
        if (converter_on) begin
            analog.chan   = use_sel;
            analog.refsel = use_ref;
            analog.temp   = (use_sel == sac_pkg::SEL_TEMP);
            analog.bypass = (use_sel <= sac_pkg::SEL_SE_LAST) || analog.temp;
            if (!analog.bypass) begin
                analog.gain = sac_pkg::sac_gain_e'({gain_range_select, use_sel[0]});
            end
        end
    end

    sac_prescaler u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (converter_on),
        .restart (restart),
        .div_sel (prescale),
        .tick    (tick)
    );

    sac_sar u_sar (
        .pclk        (pclk),
        .presetn     (presetn),
        .tick        (tick),
        .run         (converter_on),
        .start       (pend && tick),
        .first       (first),
        .cmp_bit     (cmp_bit),
        .busy        (busy),
        .done        (sar_done),
        .result      (sar_result),
        .dac_code    (dac_code),
        .sample_hold (sample_hold)
    );

    // Checks
    property p_left_hi;
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == sac_pkg::ADDR_RES_HI && left_align_result
        |=> prdata == {24'h000000, $past(result[9:2])};
    endproperty
    a_left_hi: assert property (p_left_hi) else $error("left aligned high byte wrong");

    property p_lock_set;
        @(posedge pclk) disable iff (!presetn) rd_lo |=> lock;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("low read did not lock");

    property p_lock_hold;
        @(posedge pclk) disable iff (!presetn) lock && sar_done |=> $stable(result);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked result updated");

    property p_unlock;
        @(posedge pclk) disable iff (!presetn) rd_hi |=> !lock;
    endproperty
    a_unlock: assert property (p_unlock) else $error("high read did not unlock");

    property p_flag;
        @(posedge pclk) disable iff (!presetn) sar_done |=> conversion_done_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("completion flag not set");

    property p_go_reads;
        @(posedge pclk) disable iff (!presetn) go_write |=> (pend || busy) [*2];
    endproperty
    a_go_reads: assert property (p_go_reads) else $error("go bit not held");

    property p_chan_hold;
        @(posedge pclk) disable iff (!presetn)
        busy && $past(busy) && converter_on |-> analog.chan == $past(analog.chan);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel changed in conversion");

    property p_no_queue;
        @(posedge pclk) disable iff (!presetn)
        busy && trig_edge && !sar_done ##1 busy |-> !pend;
    endproperty
    a_no_queue: assert property (p_no_queue) else $error("edge queued during conversion");

    property p_off;
        @(posedge pclk) disable iff (!presetn)
        !converter_on |-> !tick && analog.chan == 6'h00 && analog.refsel == 3'h0;
    endproperty
    a_off: assert property (p_off) else $error("analog active while off");

    c_free: cover property (@(posedge pclk) disable iff (!presetn)
        sar_done && auto_trigger_on && trigger_source_select == sac_pkg::TS_SELF ##1 pend);
    c_lost: cover property (@(posedge pclk) disable iff (!presetn) lock && sar_done);
    c_trig: cover property (@(posedge pclk) disable iff (!presetn)
        auto_evt && trigger_source_select != sac_pkg::TS_SELF);
endmodule
`default_nettype wire

/* File: verif/sac_cmp_model.sv */
// Comparator model: one input level per channel, compared with the DAC trial
`timescale 1ns/1ps
`default_nettype none
module sac_cmp_model (
    // Clock
    input  wire logic                 pclk,
    // Analog path from the design, comparator speed from the bench
    input  wire sac_pkg::sac_analog_s analog,
    input  wire logic [9:0]           dac_code,
    input  wire logic                 slow,
    // Decision back to the design
    output logic                      cmp_in
);
    logic cmp_now;
    logic cmp_late;
    // Keep the bit while the level is at or above the trial; dead while powered down
    assign cmp_now = analog.on & ({analog.chan, analog.chan[3:0]} >= dac_code);
    // Slow answer lags one system clock
    always_ff @(posedge pclk) begin
        cmp_late <= cmp_now;
    end
    assign cmp_in = slow ? cmp_late : cmp_now;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                 pclk;
    logic                 presetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [7:0]           paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [7:1]           trig_flags;
    logic                 cmp_in;
    logic                 slow;
    logic                 conversion_done_flag;
    sac_pkg::sac_analog_s analog;
    logic [9:0]           dac_code;
    logic [9:0]           v;
    logic [9:0]           v2;
    logic [5:0]           ch;
    logic [5:0]           ch2;
    logic [32:0]          expq[$];
    integer               err_count;
    integer               checks;
    integer               cycles;
    integer               seed;
    integer               n;
    integer               t0;

    sac_top u_sac_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_flags(trig_flags), .cmp_in(cmp_in), .analog(analog),
        .dac_code(dac_code), .sample_hold(), .conversion_done_flag(conversion_done_flag));
    sac_cmp_model u_sac_cmp_model (.pclk(pclk), .analog(analog), .dac_code(dac_code),
        .slow(slow), .cmp_in(cmp_in));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("Counts: %0d checks, %0d mismatches", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One APB transfer, released one edge before the next may start
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Note {pslverr, prdata} expected, then read
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // Low byte first, then high byte
    task automatic rdres(input logic [9:0] r, input logic left);
        rd(sac_pkg::ADDR_RES_LO, left ? {r[1:0], 6'h00} : r[7:0]);
        rd(sac_pkg::ADDR_RES_HI, left ? r[9:2] : r[9:8]);
    endtask

    task automatic wait_done;
        t0 = cycles;
        n = 0;
        while (conversion_done_flag !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n = n + 1;
        end
        if (n == 400) begin
            err_count = err_count + 1;
        end
    endtask

    // Completed reads compared against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            check({pslverr, prdata}, expq.size() > 0 ? expq.pop_front() : 33'h1FFFFFFFF);
        end
    end

    // Cycle count and hang limit
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            err_count = err_count + 1;
            complete_run();
        end
    end

    initial begin
        seed = 32'hFD63754F;
        {presetn, psel, penable, pwrite, paddr, pwdata, trig_flags, slow} = '0;
        {err_count, checks, cycles} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values and the unmapped place
        for (n = 0; n < 6; n++) rd(8'(n * 4), n == 5 ? 33'h100000000 : 33'h0);
        wr(sac_pkg::ADDR_INSEL, 32'h00000185);
        check(analog, 14'h0000);
        $display("test reset done");
        // Selection decode: gains, bypass, temperature, all references
        wr(sac_pkg::ADDR_CTRL_A, 32'h00000080);
        for (n = 0; n < 8; n++) begin
            ch = (n < 4) ? {5'h06, n[0]} : (n[0] ? 6'h3F : 6'h0A);
            wr(sac_pkg::ADDR_CTRL_B, {27'h0, n[1], 4'h0});
            wr(sac_pkg::ADDR_INSEL, {22'h0, n[2:0], 1'b0, ch});
            check({analog.on, analog.chan, analog.refsel, analog.bypass, analog.temp},
                  {1'b1, ch, n[2:0], n >= 4, ch == 6'h3F});
            if (n < 4) check(analog.gain, n[1:0]);
        end
        wr(sac_pkg::ADDR_CTRL_A, 32'h00000000);
        wr(sac_pkg::ADDR_CTRL_B, 32'h00000000);
        $display("test decode done");
        // First then normal single conversion, channel change mid-run
        ch = 6'($unsigned($random(seed)) % 11);
        ch2 = (ch == 6'h0A) ? 6'h00 : ch + 6'h01;
        v = {ch, ch[3:0]};
        v2 = {ch2, ch2[3:0]};
        wr(sac_pkg::ADDR_INSEL, {26'h0, ch});
        // Divide by 8 leaves the comparator synchroniser time to settle
        wr(sac_pkg::ADDR_CTRL_A, 32'h000000C2);
        t0 = cycles;
        rd(sac_pkg::ADDR_CTRL_A, 32'hC2);
        wait_done();
        check(cycles - t0 >= 200 && cycles - t0 <= 212, 1'b1);
        rd(sac_pkg::ADDR_CTRL_A, 32'h92);
        rdres(v, 1'b0);
        wr(sac_pkg::ADDR_CTRL_A, 32'h00000092);
        wr(sac_pkg::ADDR_INSEL, {25'h0, 1'b1, ch});
        wr(sac_pkg::ADDR_CTRL_A, 32'h000000C2);
        t0 = cycles;
        repeat (8) @(posedge pclk); // Conversion surely under way
        wr(sac_pkg::ADDR_INSEL, {25'h0, 1'b1, ch2});
        check(analog.chan, ch);
        wait_done();
        check(cycles - t0 >= 94 && cycles - t0 <= 103, 1'b1);
        check(analog.chan, ch2);
        rdres(v, 1'b1);
        wr(sac_pkg::ADDR_CTRL_A, 32'h00000092);
        $display("test single done");
        // Low byte read blocks the next result, flag still set
        rd(sac_pkg::ADDR_RES_LO, {v[1:0], 6'h00});
        wr(sac_pkg::ADDR_CTRL_A, 32'h000000C2);
        wait_done();
        rd(sac_pkg::ADDR_CTRL_A, 32'h92);
        rd(sac_pkg::ADDR_RES_HI, v[9:2]);
        wr(sac_pkg::ADDR_CTRL_A, 32'h000000D2);
        wait_done();
        rdres(v2, 1'b1);
        wr(sac_pkg::ADDR_CTRL_A, 32'h00000092);
        $display("test lock done");
        // Auto trigger on source 3, other sources random
        wr(sac_pkg::ADDR_CTRL_B, 32'h00000003);
        wr(sac_pkg::ADDR_CTRL_A, 32'h000000A2);
        trig_flags <= 7'($random(seed)) & 7'h7B;
        repeat (60) @(posedge pclk);
        check(conversion_done_flag, 1'b0);
        trig_flags[3] <= 1'b1;
        repeat (10) @(posedge pclk);
        trig_flags[3] <= 1'b0;
        repeat (2) @(posedge pclk);
        trig_flags[3] <= 1'b1;
        wait_done();
        rd(sac_pkg::ADDR_CTRL_A, 32'hB2);
        wr(sac_pkg::ADDR_CTRL_A, 32'h000000B2);
        repeat (130) @(posedge pclk);
        check(conversion_done_flag, 1'b0);
        trig_flags <= 7'h00;
        wr(sac_pkg::ADDR_CTRL_A, 32'h000000E2);
        rd(sac_pkg::ADDR_CTRL_A, 32'hE2);
        wait_done();
        wr(sac_pkg::ADDR_CTRL_A, 32'h000000B2);
        $display("test trigger done");
        // Free running on own completion, slow comparator
        slow <= 1'b1;
        wr(sac_pkg::ADDR_CTRL_B, 32'h00000000);
        wr(sac_pkg::ADDR_CTRL_A, 32'h000000E2);
        wait_done();
        rd(sac_pkg::ADDR_CTRL_A, 32'hF2);
        wr(sac_pkg::ADDR_CTRL_A, 32'h000000B2);
        wait_done();
        check(cycles - t0 <= 112 && conversion_done_flag === 1'b1, 1'b1);
        rdres(v2, 1'b1);
        // Off: analog path dead, go refused
        wr(sac_pkg::ADDR_CTRL_A, 32'h00000010);
        check(analog, 14'h0000);
        wr(sac_pkg::ADDR_CTRL_A, 32'h00000040);
        repeat (60) @(posedge pclk);
        rd(sac_pkg::ADDR_CTRL_A, 32'h00);
        $display("test free running done");
        complete_run();
    end
endmodule
`default_nettype wire
